// >>> msg_flow_pkg.sv
// Constants for the host-side serial message flow controller
`default_nettype none
package msg_flow_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned QUIET_MS = 50;
   localparam int unsigned QUIET_CYC = (CLK_HZ / 1000) * QUIET_MS;
   localparam int unsigned RATE_MAX = 20;
   localparam int unsigned RATE_WIN_MS = 1000;
   localparam int unsigned RATE_WIN_CYC = (CLK_HZ / 1000) * RATE_WIN_MS;
   localparam int unsigned POLL_MS = 10;
   localparam int unsigned POLL_CYC = (CLK_HZ / 1000) * POLL_MS;
   localparam int unsigned POLL_LIMIT = 20;
   localparam int unsigned BAUD = 9600;
   localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
   localparam int unsigned DATA_BITS = 7;
   localparam int unsigned FRAME_BITS = 10;
   localparam int unsigned MSG_MAX = 64;
   localparam logic [6:0] CHAR_CR = 7'h0d;
   localparam logic [6:0] CHAR_LF = 7'h0a;
   localparam logic [6:0] CHAR_QMARK = 7'h3f;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEND = 3'b001,
      ST_CR = 3'b010,
      ST_LF = 3'b011,
      ST_RECV = 3'b100,
      ST_QUIET = 3'b101
   } flow_state_t;
endpackage
`default_nettype wire

// >>> msg_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module msg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be power of 2");
   end
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff;
   logic [AW:0] rd_ff;
   logic push;
   logic pop;
   assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data = mem_ff[rd_ff[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop) rd_ff <= rd_ff + 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (push) mem_ff[wr_ff[AW-1:0]] <= in_data;
   end
endmodule // msg_fifo

// >>> msg_flow_host.sv
// Host controller: sends messages to the instrument and paces the link
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - A command goes out as one unbroken string with its terminators.
// - After a command's last character the link stays quiet for 50 ms.
// - No more than 20 exchanges start in any one-second window.
// - A query goes out as one unbroken string with its terminators.
// - After a query the receiver is live at once.
// - Every response character up to the line feed is taken.
// - Nothing is sent during a response, then 50 ms of quiet follow.
// - Each message ends with carriage return then line feed.
// - A response ends on line feed or after 20 empty 10 ms polls.
// - The port runs 9600 baud, 7 data bits, parity, one stop bit.
// - The link is half duplex; sending and receiving never overlap.
// - A character is start, 7 data, odd parity and stop bits.
// - A message is at most 64 characters including terminators.
module msg_flow_host
   import msg_flow_pkg::*;
#(
   parameter int FIFO_DEPTH = 32,
   parameter int unsigned QUIET_CYCLES = QUIET_CYC,
   parameter int unsigned RATE_CYCLES = RATE_WIN_CYC,
   parameter int unsigned POLL_CYCLES = POLL_CYC,
   parameter int unsigned BIT_CYCLES = BIT_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic msg_valid,
   output logic msg_ready,
   input wire logic [6:0] msg_char,
   input wire logic msg_last,
   output logic rsp_valid,
   output logic [6:0] rsp_char,
   output logic rsp_end,
   output logic rsp_timeout,
   output logic rsp_parity_err,
   output logic busy,
   output logic txd,
   input wire logic rxd
);
   import msg_flow_pkg::*;
   // Bit counters are 16 bits, rate slots indexed by 5 bits
   if (BIT_CYCLES < 4 || BIT_CYCLES > 65535 || QUIET_CYCLES < 1
       || POLL_CYCLES < 1 || RATE_MAX > 32) begin : g_bad_timing
      $error("Timing parameters out of range");
   end
   if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("FIFO depth too small");
   end
   ////////////////////////////////////////////////////////////////////////////
   // Message FIFO: sending starts once the whole message is queued or the queue is full
   logic f_valid;
   logic f_ready;
   logic [7:0] f_data;
   logic f_in_ready;
   logic q_last_seen_ff;
   logic q_has_query_ff;
   logic accept;
   logic [7:0] msg_len_ff;
   logic tx_done;
   logic tx_start_ff;
   logic [6:0] tx_char_ff;
   // Limit: 62 payload chars so total with CR LF stays at 64
   assign accept = msg_valid && msg_ready;
   msg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(accept),
      .in_ready(f_in_ready),
      .in_data({msg_last, msg_char}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   flow_state_t state_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         msg_ready <= 1'b0;
      end else begin
         msg_ready <= f_in_ready && !q_last_seen_ff && !accept
                      && (msg_len_ff < 8'(MSG_MAX - 2));
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q_last_seen_ff <= 1'b0;
         q_has_query_ff <= 1'b0;
         msg_len_ff <= '0;
      end else if (state_ff == ST_QUIET && q_last_seen_ff
                   && f_valid == 1'b0 && tx_done) begin
         q_last_seen_ff <= 1'b0;
         q_has_query_ff <= 1'b0;
         msg_len_ff <= '0;
      end else if (accept) begin
         msg_len_ff <= msg_len_ff + 1'b1;
         if (msg_last || msg_len_ff == 8'(MSG_MAX - 3))
            q_last_seen_ff <= 1'b1;
         if (msg_char == CHAR_QMARK) q_has_query_ff <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Transmitter: 1 start, 7 data, odd parity, 1 stop
   logic tx_start;
   logic [6:0] tx_char;
   logic [9:0] tx_shift_ff;
   logic [3:0] tx_bits_ff;
   logic [15:0] tx_cnt_ff;
   assign tx_done = tx_bits_ff == 4'd0;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_shift_ff <= '1;
         tx_bits_ff <= '0;
         tx_cnt_ff <= '0;
         txd <= 1'b1;
      end else if (tx_start) begin
         tx_shift_ff <= {1'b1, ~^tx_char, tx_char, 1'b0};
         tx_bits_ff <= 4'(FRAME_BITS);
         tx_cnt_ff <= '0;
      end else if (!tx_done) begin
         txd <= tx_shift_ff[0];
         if (tx_cnt_ff == 16'(BIT_CYCLES - 1)) begin
            tx_cnt_ff <= '0;
            tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
            tx_bits_ff <= tx_bits_ff - 1'b1;
         end else begin
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
         end
      end else begin
         txd <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Receiver, active only in the receive state (half duplex)
   logic rx_en;
   logic rx_active_ff;
   logic [15:0] rx_cnt_ff;
   logic [3:0] rx_bit_ff;
   logic [8:0] rx_shift_ff;
   logic rx_got;
   assign rx_en = state_ff == ST_RECV;
   assign rx_got = rx_active_ff && rx_bit_ff == 4'd9
                   && rx_cnt_ff == 16'(BIT_CYCLES - 1);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_active_ff <= 1'b0;
         rx_cnt_ff <= '0;
         rx_bit_ff <= '0;
         rx_shift_ff <= '0;
      end else if (!rx_en) begin
         rx_active_ff <= 1'b0;
      end else if (!rx_active_ff) begin
         if (!rxd) begin
            rx_active_ff <= 1'b1;
            rx_cnt_ff <= 16'(BIT_CYCLES / 2);
            rx_bit_ff <= '0;
         end
      end else if (rx_cnt_ff == 16'(BIT_CYCLES - 1)) begin
         rx_cnt_ff <= '0;
         if (rx_bit_ff == 4'd9) begin
            rx_active_ff <= 1'b0;
         end else begin
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff != 4'd0) rx_shift_ff <= {rxd, rx_shift_ff[8:1]};
         end
      end else begin
         rx_cnt_ff <= rx_cnt_ff + 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Flow control state machine
   logic [31:0] quiet_ff;
   logic [31:0] poll_cnt_ff;
   logic [4:0] empty_polls_ff;
   logic rate_ok;
   logic start_ex;
   // A full queue starts early: the writer must then keep pace
   assign start_ex = state_ff == ST_IDLE && (q_last_seen_ff || !f_in_ready)
                     && rate_ok && quiet_ff == 0;
   assign f_ready = state_ff == ST_SEND && tx_done && !tx_start_ff;
   assign tx_start = tx_start_ff;
   assign tx_char = tx_char_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_IDLE;
         tx_start_ff <= 1'b0;
         tx_char_ff <= '0;
         quiet_ff <= '0;
         poll_cnt_ff <= '0;
         empty_polls_ff <= '0;
         rsp_valid <= 1'b0;
         rsp_char <= '0;
         rsp_end <= 1'b0;
         rsp_timeout <= 1'b0;
         rsp_parity_err <= 1'b0;
         busy <= 1'b0;
      end else begin
         tx_start_ff <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_end <= 1'b0;
         rsp_timeout <= 1'b0;
         busy <= state_ff != ST_IDLE;
         if (quiet_ff != 0) quiet_ff <= quiet_ff - 1'b1;
         unique case (state_ff)
            ST_IDLE: begin
               if (start_ex) state_ff <= ST_SEND;
            end
            ST_SEND: begin
               // Characters back to back, two idle cycles between a stop bit and the next start bit
               if (f_valid && f_ready) begin
                  tx_start_ff <= 1'b1;
                  tx_char_ff <= f_data[6:0];
                  if (f_data[7] || !q_last_seen_ff || f_valid)
                     if (f_data[7]) state_ff <= ST_CR;
               end else if (!f_valid && tx_done && !tx_start_ff
                            && q_last_seen_ff) begin
                  state_ff <= ST_CR;
               end
            end
            ST_CR: begin
               if (tx_done && !tx_start_ff) begin
                  tx_start_ff <= 1'b1;
                  tx_char_ff <= CHAR_CR;
                  state_ff <= ST_LF;
               end
            end
            ST_LF: begin
               if (tx_done && !tx_start_ff && tx_char_ff == CHAR_CR) begin
                  tx_start_ff <= 1'b1;
                  tx_char_ff <= CHAR_LF;
               end else if (tx_done && !tx_start_ff) begin
                  poll_cnt_ff <= '0;
                  empty_polls_ff <= '0;
                  quiet_ff <= QUIET_CYCLES;
                  state_ff <= q_has_query_ff ? ST_RECV : ST_QUIET;
               end
            end
            ST_RECV: begin
               // Stop bit still on the line when a character is taken
               quiet_ff <= QUIET_CYCLES + BIT_CYCLES;
               if (rx_got) begin
                  poll_cnt_ff <= '0;
                  empty_polls_ff <= '0;
                  rsp_valid <= 1'b1;
                  // Data sits in [7:1], parity in [8]
                  rsp_char <= rx_shift_ff[7:1];
                  rsp_parity_err <= ~^rx_shift_ff[8:1];
                  if (rx_shift_ff[7:1] == CHAR_LF) begin
                     rsp_end <= 1'b1;
                     state_ff <= ST_QUIET;
                  end
               end else if (poll_cnt_ff == POLL_CYCLES - 1) begin
                  poll_cnt_ff <= '0;
                  if (empty_polls_ff == 5'(POLL_LIMIT - 1)) begin
                     rsp_timeout <= 1'b1;
                     state_ff <= ST_QUIET;
                  end else begin
                     empty_polls_ff <= empty_polls_ff + 1'b1;
                  end
               end else begin
                  poll_cnt_ff <= poll_cnt_ff + 1'b1;
               end
            end
            ST_QUIET: begin
               if (q_last_seen_ff == 1'b0) state_ff <= ST_IDLE;
               else if (!f_valid) state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Rate limiter: sliding window of RATE_MAX start times, one slot each
   logic [31:0] slot_ff [RATE_MAX];
   logic [4:0] free_idx;
   always_comb begin
      rate_ok = 1'b0;
      free_idx = '0;
      for (int i = RATE_MAX - 1; i >= 0; i--) begin
         if (slot_ff[i] == 0) begin
            rate_ok = 1'b1;
            free_idx = 5'(i);
         end
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < RATE_MAX; i++) slot_ff[i] <= '0;
      end else begin
         for (int i = 0; i < RATE_MAX; i++) begin
            if (slot_ff[i] != 0) slot_ff[i] <= slot_ff[i] - 1'b1;
         end
         if (start_ex) slot_ff[free_idx] <= RATE_CYCLES;
      end
   end
endmodule // msg_flow_host
`default_nettype wire

// >>> msg_flow_host_asserts.sv
// Concurrent checks on the host message flow controller ports
`timescale 1ns/1ps
`default_nettype none
module msg_flow_host_asserts
   import msg_flow_pkg::*;
#(
   parameter int unsigned QUIET_CYCLES = QUIET_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic msg_valid,
   input wire logic msg_ready,
   input wire logic [6:0] msg_char,
   input wire logic msg_last,
   input wire logic rsp_valid,
   input wire logic [6:0] rsp_char,
   input wire logic rsp_end,
   input wire logic rsp_timeout,
   input wire logic rsp_parity_err,
   input wire logic busy,
   input wire logic txd,
   input wire logic rxd
);
   int unsigned quiet_ff;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////
   // Two cycles of slack: the end pulse trails the last received bit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         quiet_ff <= 0;
      end else if (rsp_end || rsp_timeout) begin
         quiet_ff <= QUIET_CYCLES - 2;
      end else if (quiet_ff != 0) begin
         quiet_ff <= quiet_ff - 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_rx_no_tx;
      rsp_valid |-> txd;
   endproperty
   a_rx_no_tx: assert property (p_rx_no_tx)
      else $error("line driven during response");
   property p_end_lf;
      rsp_end |-> rsp_valid && rsp_char == CHAR_LF;
   endproperty
   a_end_lf: assert property (p_end_lf)
      else $error("response end not on line feed");
   property p_to_alone;
      rsp_timeout |-> !rsp_valid && !rsp_end;
   endproperty
   a_to_alone: assert property (p_to_alone)
      else $error("timeout together with a character");
   property p_take_gap;
      msg_valid && msg_ready |=> !msg_ready;
   endproperty
   a_take_gap: assert property (p_take_gap)
      else $error("ready held after accept");
   property p_quiet;
      quiet_ff != 0 |-> txd;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("send inside quiet time");
   property p_fell_busy;
      $fell(txd) |-> ##[0:2] busy;
   endproperty
   a_fell_busy: assert property (p_fell_busy)
      else $error("start bit outside an exchange");
   property p_ready_rx;
      rsp_valid |-> !msg_ready;
   endproperty
   a_ready_rx: assert property (p_ready_rx)
      else $error("ready while receiving");
   property p_par_level;
      $changed(rsp_parity_err) |-> rsp_valid;
   endproperty
   a_par_level: assert property (p_par_level)
      else $error("parity flag moved without a character");
endmodule // msg_flow_host_asserts
bind msg_flow_host msg_flow_host_asserts #(.QUIET_CYCLES(QUIET_CYCLES))
   u_msg_flow_host_asserts (.clock(clock), .arst_n(arst_n),
   .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_char(msg_char),
   .msg_last(msg_last), .rsp_valid(rsp_valid), .rsp_char(rsp_char),
   .rsp_end(rsp_end), .rsp_timeout(rsp_timeout),
   .rsp_parity_err(rsp_parity_err), .busy(busy), .txd(txd), .rxd(rxd));
`default_nettype wire

// >>> instr_model.sv
// Behavioural instrument on the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module instr_model #(
   parameter int BIT_CYCLES = 8,
   parameter int DELAY = 20
) (
   input wire logic clock,
   input wire logic line_in,
   output logic line_out,
   input wire logic mute,
   input wire logic bad_par
);
   logic [6:0] cur[$];
   logic [6:0] last_msg[$];
   int cyc = 0;
   int last_end = -100000;
   int min_gap = 1000000;
   int len_max = 0;
   int starts[$];
   int n_frame_err = 0;
   always @(posedge clock) begin
      cyc <= cyc + 1;
   end
   task automatic put(input logic [6:0] c, input logic flip);
      logic [9:0] f;
      f = {1'b1, ~^c ^ flip, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BIT_CYCLES) @(posedge clock);
      end
   endtask
   initial begin
      logic [6:0] c;
      logic p;
      logic has_q;
      line_out = 1'b1;
      has_q = 0;
      forever begin
         @(negedge line_in);
         if (line_in !== 1'b0) continue;
         if (cur.size() == 0) begin
            starts.push_back(cyc);
            if (cyc - last_end < min_gap) min_gap = cyc - last_end;
         end
         repeat (BIT_CYCLES / 2) @(posedge clock);
         for (int i = 0; i < 7; i++) begin
            repeat (BIT_CYCLES) @(posedge clock);
            c[i] = line_in;
         end
         repeat (BIT_CYCLES) @(posedge clock);
         p = line_in;
         repeat (BIT_CYCLES) @(posedge clock);
         if ((^c ^ p) !== 1'b1 || line_in !== 1'b1) n_frame_err++;
         cur.push_back(c);
         last_end = cyc;
         if (c == 7'h3f) has_q = 1;
         if (c == 7'h0a) begin
            last_msg = cur;
            if (cur.size() > len_max) len_max = cur.size();
            cur = {};
            // Answers only a query, never on its own
            if (has_q && !mute) begin
               repeat (DELAY) @(posedge clock);
               put(7'h37, bad_par);
               put(7'h0d, 1'b0);
               put(7'h0a, 1'b0);
               last_end = cyc;
            end
            has_q = 0;
         end
      end
   end
endmodule // instr_model
`default_nettype wire

// >>> msg_flow_host_tb_top.sv
// Self-checking testbench for the host message flow controller
`timescale 1ns/1ps
`default_nettype none
module msg_flow_host_tb_top;
   import msg_flow_pkg::*;
   localparam int QC = 50;
   localparam int RC = 8000;
   localparam int PC = 100;
   localparam int BC = 8;
   logic clock = 0;
   logic arst_n = 0;
   logic msg_valid = 0;
   logic msg_last = 0;
   logic [6:0] msg_char = 7'h00;
   logic msg_ready, rsp_valid, rsp_end, rsp_timeout, rsp_parity_err;
   logic busy, txd, rxd;
   logic [6:0] rsp_char;
   logic mute = 0;
   logic bad_par = 0;
   int n_mismatch = 0;
   int checked = 0;
   int n_to = 0;
   int n_perr = 0;
   int n_end = 0;
   logic [6:0] rq[$];
   always #12.5 clock = ~clock;
   msg_flow_host #(.QUIET_CYCLES(QC), .RATE_CYCLES(RC), .POLL_CYCLES(PC),
      .BIT_CYCLES(BC)) u_msg_flow_host (.clock(clock), .arst_n(arst_n),
      .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_char(msg_char),
      .msg_last(msg_last), .rsp_valid(rsp_valid), .rsp_char(rsp_char),
      .rsp_end(rsp_end), .rsp_timeout(rsp_timeout),
      .rsp_parity_err(rsp_parity_err), .busy(busy), .txd(txd), .rxd(rxd));
   instr_model #(.BIT_CYCLES(BC)) u_instr_model (.clock(clock),
      .line_in(txd), .line_out(rxd), .mute(mute), .bad_par(bad_par));
   // Pulses stand a whole cycle, so mid-cycle sampling sees each once
   always @(negedge clock) begin
      if (rsp_valid === 1'b1) rq.push_back(rsp_char);
      if (rsp_end === 1'b1) n_end++;
      if (rsp_valid === 1'b1 && rsp_parity_err === 1'b1) n_perr++;
      if (rsp_timeout === 1'b1) n_to++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic send(input string s);
      byte b;
      for (int i = 0; i < s.len(); i++) begin
         @(negedge clock);
         b = s[i];
         msg_char = b[6:0];
         msg_last = (i == s.len() - 1);
         msg_valid = 1;
         while (msg_ready !== 1'b1) @(negedge clock);
         @(posedge clock);
      end
      @(negedge clock);
      msg_valid = 0;
   endtask
   // Busy lags a cycle and a start may wait on the rate limit,
   // so demand a run of idle samples with the queue open again
   task automatic idle();
      int q;
      q = 0;
      repeat (4) @(negedge clock);
      while (q < 8) begin
         @(negedge clock);
         q = (busy === 1'b0 && msg_ready === 1'b1) ? q + 1 : 0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_rate();
      int n;
      for (int i = 0; i < 21; i++) send("R");
      idle();
      n = u_instr_model.starts.size();
      n = u_instr_model.starts[n - 1] - u_instr_model.starts[n - 21];
      chk("rate_min", 1, n >= RC);
      chk("rate_max", 1, n <= RC + 400);
      chk("gap", 1, u_instr_model.min_gap >= QC);
      $display("t_rate done");
   endtask
   task automatic t_cmd();
      rq = {};
      send("A");
      idle();
      chk("cmd_len", 3, u_instr_model.last_msg.size());
      chk("cmd_cr", CHAR_CR, u_instr_model.last_msg[1]);
      chk("cmd_lf", CHAR_LF, u_instr_model.last_msg[2]);
      chk("cmd_rsp", 0, rq.size());
      $display("t_cmd done");
   endtask
   task automatic t_query(input logic flip);
      rq = {};
      n_perr = 0;
      n_end = 0;
      bad_par = flip;
      send("Q?");
      idle();
      chk("q_len", 4, u_instr_model.last_msg.size());
      chk("q_n", 3, rq.size());
      chk("q_c0", 7'h37, rq[0]);
      chk("q_c2", CHAR_LF, rq[2]);
      chk("q_end", 1, n_end);
      chk("q_perr", flip, n_perr);
      chk("gap", 1, u_instr_model.min_gap >= QC);
      bad_par = 0;
      $display("t_query done");
   endtask
   task automatic t_mute();
      int e;
      mute = 1;
      n_to = 0;
      send("Z?");
      do @(negedge clock); while (n_to == 0);
      e = u_instr_model.cyc - u_instr_model.last_end;
      chk("to_win", 1, e >= 19 * PC && e <= 21 * PC);
      idle();
      mute = 0;
      $display("t_mute done");
   endtask
   task automatic t_long();
      send({63{"B"}});
      idle();
      chk("long_max", 64, u_instr_model.len_max);
      chk("long_tail", 3, u_instr_model.last_msg.size());
      chk("frames", 0, u_instr_model.n_frame_err);
      $display("t_long done");
   endtask
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clock);
      chk("txd_rst", 1, txd);
      chk("rdy_rst", 0, msg_ready);
      @(negedge clock);
      arst_n = 1;
      t_rate();
      t_cmd();
      t_query(1'b0);
      t_query(1'b1);
      t_mute();
      t_long();
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      $display("watchdog expired");
      complete_run();
   end
endmodule // msg_flow_host_tb_top
`default_nettype wire
